// ### design/usb_sie_ctrl_map.svh
`ifndef USB_SIE_CTRL_MAP_SVH
`define USB_SIE_CTRL_MAP_SVH

`define REG_ENGINE_CONTROL  2'h0
`define REG_DEVICE_ADDRESS  2'h1
`define REG_ENDPOINT_STALL  2'h2
`define REG_ENGINE_STATUS   2'h3

`define CTL_PULLUP_BIT      7
`define CTL_OSC_BIT         6
`define CTL_SLEEP2_BIT      4
`define CTL_CLKON_BIT       3
`define CTL_EPSEL_HI_BIT    1
`define CTL_EPSEL_LO_BIT    0
`define CTL_WMASK           8'hDB
`define CTL_RESET           8'h00

`define ADR_WAKE_BIT        0
`define ADR_RESET           8'h00

`define STL_WMASK           8'h77
`define STL_RESET           8'h00

`define STS_NAKMASK_BIT     7
`define STS_RXERR_BIT       6
`define STS_NORESP_BIT      4
`define STS_IN_BIT          3
`define STS_OUT_BIT         2
`define STS_FIFOERR_BIT     1
`define STS_APPLY_BIT       0
`define STS_RESET           8'h00

`endif

// ### design/usb_sie_ctrl_pkg.sv
package usb_sie_ctrl_pkg;

  typedef enum logic [1:0] {
    EP_CTRL0,
    EP_ONE,
    EP_TWO
  } ep_sel_type;

  typedef struct packed {
    logic       bus_reset;
    logic       setup_token;
    logic       suspend;
    logic       in_token;
    logic       out_nonzero;
    logic       nak_sent;
    logic       rx_integrity_err;
    logic       no_response;
    logic       fifo_err;
    logic       in_read_ok;
  } engine_event_type;

endpackage

// ### design/usb_sie_control_status.sv
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "usb_sie_ctrl_map.svh"

// Overview of operation
// RULE1 - set sleep flag; interrupt on rising edge
// RULE2 - control bit 7 drives D-minus pull-up
// RULE3 - osc bit: 0 is 12MHz, 1 is 6MHz
// RULE4 - endpoint select 00/01/1x routes FIFO
// RULE5 - address bits 7..1 hold device address
// RULE6 - address bit 0 enables remote wakeup
// RULE7 - address register resets to 00H
// RULE8 - firmware writes address after SETUP stage
// RULE9 - stall bits 6..4 are OUT stalls
// RULE10 - stall bits 2..0 are IN stalls
// RULE11 - firmware sets stall on endpoint misbehaviour
// RULE12 - bus reset or SETUP clears stalls
// RULE13 - NAK mask gates NAK interrupts
// RULE14 - set integrity error; firmware clears
// RULE15 - set no-response error; firmware clears
// RULE16 - read-only bit shows IN token
// RULE17 - OUT flag set, SETUP or firmware clears
// RULE18 - shared FIFO access error flag
// RULE19 - apply mode 1: adopt after IN read
// RULE20 - apply mode 0: adopt on write
// RULE21 - firmware clears apply bit after SETUP
// RULE22 - firmware enables clock, clears sleep2
// RULE23 - hardware set beats firmware clear
module usb_sie_control_status (
  input  wire logic                               core_clk_i,
  input  wire logic                               rst_i,
  input  wire logic                               clk_en_i,
  input  wire logic [1:0]                         reg_addr_i,
  input  wire logic [7:0]                         reg_wdata_i,
  input  wire logic                               reg_wr_i,
  input  wire logic                               reg_rd_i,
  output logic      [7:0]                         reg_rdata_o,
  input  wire usb_sie_ctrl_pkg::engine_event_type evt_i,
  output logic                                    usb_irq_o,
  output logic                                    dminus_pullup_o,
  output logic                                    osc_freq_select_o,
  output logic                                    engine_clock_on_o,
  output logic                                    second_sleep_control_o,
  output usb_sie_ctrl_pkg::ep_sel_type            fifo_ep_o,
  output logic      [6:0]                         active_addr_o,
  output logic                                    remote_wake_allow_o,
  output logic      [2:0]                         out_halt_o,
  output logic      [2:0]                         in_halt_o
);

  logic [7:0] ctl_r;
  logic [7:0] adr_r;
  logic [7:0] stl_r;
  logic       sleep_r;
  logic       sleep_d_r;
  logic       nak_mask_r;
  logic       rxerr_r;
  logic       noresp_r;
  logic       in_tok_r;
  logic       out_r;
  logic       fifoerr_r;
  logic       apply_r;
  logic [6:0] active_r;
  logic       irq_r;
  logic [7:0] rdata_r;
  logic [7:0] sts_view;
  logic       wr_ctl;
  logic       wr_adr;
  logic       wr_stl;
  logic       wr_sts;

  assign wr_ctl = clk_en_i & reg_wr_i & (reg_addr_i == `REG_ENGINE_CONTROL);
  assign wr_adr = clk_en_i & reg_wr_i & (reg_addr_i == `REG_DEVICE_ADDRESS);
  assign wr_stl = clk_en_i & reg_wr_i & (reg_addr_i == `REG_ENDPOINT_STALL);
  assign wr_sts = clk_en_i & reg_wr_i & (reg_addr_i == `REG_ENGINE_STATUS);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_r <= `CTL_RESET;
    end else if (wr_ctl) begin
      ctl_r <= reg_wdata_i & `CTL_WMASK;
    end
  end

  assign dminus_pullup_o        = ctl_r[`CTL_PULLUP_BIT]; // RULE2
  assign osc_freq_select_o      = ctl_r[`CTL_OSC_BIT]; // RULE3
  assign engine_clock_on_o      = ctl_r[`CTL_CLKON_BIT];
  assign second_sleep_control_o = ctl_r[`CTL_SLEEP2_BIT];

  // endpoint 2 for both upper codes
  always_comb begin
    case ({ctl_r[`CTL_EPSEL_HI_BIT], ctl_r[`CTL_EPSEL_LO_BIT]})
      2'h0:    fifo_ep_o = usb_sie_ctrl_pkg::EP_CTRL0; // RULE4
      2'h1:    fifo_ep_o = usb_sie_ctrl_pkg::EP_ONE; // RULE4
      default: fifo_ep_o = usb_sie_ctrl_pkg::EP_TWO; // RULE4
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      adr_r <= `ADR_RESET; // RULE7
    end else if (wr_adr) begin
      adr_r <= reg_wdata_i; // RULE5 RULE6
    end
  end

  assign remote_wake_allow_o = adr_r[`ADR_WAKE_BIT]; // RULE6

  // address actually answered on the bus
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_r <= 7'h00;
    end else if (clk_en_i) begin
      if (wr_adr && !apply_r) begin
        active_r <= reg_wdata_i[7:1]; // RULE20
      end else if (apply_r && evt_i.in_read_ok) begin
        active_r <= adr_r[7:1]; // RULE19
      end
    end
  end

  assign active_addr_o = active_r;

  // hardware clears override firmware sets: a setup resets endpoint state
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stl_r <= `STL_RESET;
    end else if (clk_en_i) begin
      if (evt_i.bus_reset || evt_i.setup_token) begin
        stl_r <= `STL_RESET; // RULE12
      end else if (wr_stl) begin
        stl_r <= reg_wdata_i & `STL_WMASK; // RULE11
      end
    end
  end

  assign out_halt_o = stl_r[6:4]; // RULE9
  assign in_halt_o  = stl_r[2:0]; // RULE10

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_r   <= 1'b0;
      sleep_d_r <= 1'b0;
    end else if (clk_en_i) begin
      sleep_r   <= evt_i.suspend; // RULE1
      sleep_d_r <= sleep_r;
    end
  end

  // firmware-written status bits
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nak_mask_r <= 1'b0;
      apply_r    <= 1'b0;
    end else if (wr_sts) begin
      nak_mask_r <= reg_wdata_i[`STS_NAKMASK_BIT];
      apply_r    <= reg_wdata_i[`STS_APPLY_BIT];
    end
  end

  // sticky flags: set wins over a firmware zero in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxerr_r   <= 1'b0;
      noresp_r  <= 1'b0;
      fifoerr_r <= 1'b0;
    end else if (clk_en_i) begin
      if (evt_i.rx_integrity_err) begin
        rxerr_r <= 1'b1; // RULE14 RULE23
      end else if (wr_sts && !reg_wdata_i[`STS_RXERR_BIT]) begin
        rxerr_r <= 1'b0; // RULE14
      end
      if (evt_i.no_response) begin
        noresp_r <= 1'b1; // RULE15 RULE23
      end else if (wr_sts && !reg_wdata_i[`STS_NORESP_BIT]) begin
        noresp_r <= 1'b0; // RULE15
      end
      if (evt_i.fifo_err) begin
        fifoerr_r <= 1'b1; // RULE18 RULE23
      end else if (wr_sts && !reg_wdata_i[`STS_FIFOERR_BIT]) begin
        fifoerr_r <= 1'b0; // RULE18
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_r <= 1'b0;
    end else if (clk_en_i) begin
      if (evt_i.out_nonzero) begin
        out_r <= 1'b1; // RULE17 RULE23
      end else if (evt_i.setup_token) begin
        out_r <= 1'b0; // RULE17
      end else if (wr_sts && !reg_wdata_i[`STS_OUT_BIT]) begin
        out_r <= 1'b0; // RULE17
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_tok_r <= 1'b0;
    end else if (clk_en_i) begin
      in_tok_r <= evt_i.in_token; // RULE16
    end
  end

  // registered interrupt: one cycle per sleep rise, high as long as an unmasked nak_sent lasts
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else if (clk_en_i) begin
      irq_r <= (sleep_r & ~sleep_d_r) | (evt_i.nak_sent & ~nak_mask_r); // RULE1 RULE13
    end
  end

  assign usb_irq_o = irq_r;

  always_comb begin
    sts_view = 8'h00;
    sts_view[`STS_NAKMASK_BIT] = nak_mask_r;
    sts_view[`STS_RXERR_BIT]   = rxerr_r;
    sts_view[`STS_NORESP_BIT]  = noresp_r;
    sts_view[`STS_IN_BIT]      = in_tok_r;
    sts_view[`STS_OUT_BIT]     = out_r;
    sts_view[`STS_FIFOERR_BIT] = fifoerr_r;
    sts_view[`STS_APPLY_BIT]   = apply_r;
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else if (clk_en_i) begin
      if (reg_rd_i) begin
        case (reg_addr_i)
          `REG_ENGINE_CONTROL: rdata_r <= ctl_r;
          `REG_DEVICE_ADDRESS: rdata_r <= adr_r;
          `REG_ENDPOINT_STALL: rdata_r <= stl_r;
          `REG_ENGINE_STATUS:  rdata_r <= sts_view;
          default:             rdata_r <= 8'h00;
        endcase
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  assign reg_rdata_o = rdata_r;

  chk_sleep_irq : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE1
    clk_en_i [*2] ##0 $rose(sleep_r) |=> usb_irq_o)
    else $error("sleep rise gave no interrupt");

  chk_nak_masked : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE13
    clk_en_i && nak_mask_r && evt_i.nak_sent && !(sleep_r && !sleep_d_r) |=> !usb_irq_o)
    else $error("masked nak raised interrupt");

  chk_stall_clear : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE12
    clk_en_i && (evt_i.bus_reset || evt_i.setup_token) |=> stl_r == 8'h00)
    else $error("stall bits not cleared");

  chk_rxerr_sticky : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE14
    clk_en_i && evt_i.rx_integrity_err |=> rxerr_r)
    else $error("integrity error not set");

  chk_noresp_set : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE15
    clk_en_i && evt_i.no_response |=> noresp_r)
    else $error("no-response flag not set");

  chk_out_flag : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE17
    clk_en_i && evt_i.setup_token && !evt_i.out_nonzero |=> !out_r)
    else $error("out flag survived setup");

  chk_fifo_err : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE18
    clk_en_i && evt_i.fifo_err |=> fifoerr_r)
    else $error("fifo error not set");

  chk_addr_now : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE20
    wr_adr && !apply_r |=> {active_addr_o, 1'b0} == ($past(reg_wdata_i) & 8'hFE))
    else $error("address not adopted on write");

  chk_addr_later : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE19
    clk_en_i && apply_r && !evt_i.in_read_ok |=> $stable(active_addr_o))
    else $error("address adopted before IN read");

  chk_nak_irq : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE13
    clk_en_i && evt_i.nak_sent && !nak_mask_r |=> usb_irq_o)
    else $error("unmasked nak gave no interrupt");

  chk_sleep_flag : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE1
    clk_en_i && evt_i.suspend |=> sleep_r)
    else $error("sleep flag not set");

  chk_irq_cause : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE1 RULE13
    clk_en_i && !evt_i.nak_sent && !(sleep_r && !sleep_d_r) |=> !usb_irq_o)
    else $error("interrupt without a cause");

  chk_rxerr_clear : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE14
    wr_sts && !reg_wdata_i[`STS_RXERR_BIT] && !evt_i.rx_integrity_err |=> !rxerr_r)
    else $error("integrity error not cleared");

  chk_noresp_clear : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE15
    wr_sts && !reg_wdata_i[`STS_NORESP_BIT] && !evt_i.no_response |=> !noresp_r)
    else $error("no-response flag not cleared");

  chk_fifo_clear : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE18
    wr_sts && !reg_wdata_i[`STS_FIFOERR_BIT] && !evt_i.fifo_err |=> !fifoerr_r)
    else $error("fifo error not cleared");

  chk_out_clear : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE17
    wr_sts && !reg_wdata_i[`STS_OUT_BIT] && !evt_i.out_nonzero |=> !out_r)
    else $error("out flag not cleared");

  chk_out_set : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE17 RULE23
    clk_en_i && evt_i.out_nonzero |=> out_r)
    else $error("out flag not set");

  chk_out_hold : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE17
    clk_en_i && out_r && !evt_i.setup_token && !wr_sts |=> out_r)
    else $error("out flag dropped by itself");

  chk_rxerr_hold : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE14
    clk_en_i && rxerr_r && !wr_sts |=> rxerr_r)
    else $error("integrity error dropped by itself");

  chk_noresp_hold : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE15
    clk_en_i && noresp_r && !wr_sts |=> noresp_r)
    else $error("no-response flag dropped by itself");

  chk_fifo_hold : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE18
    clk_en_i && fifoerr_r && !wr_sts |=> fifoerr_r)
    else $error("fifo error dropped by itself");

  chk_stall_hold : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE9 RULE10
    clk_en_i && !evt_i.bus_reset && !evt_i.setup_token && !wr_stl |=> $stable(stl_r))
    else $error("stall bits moved by themselves");

  chk_stall_write : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE9 RULE10
    wr_stl && !evt_i.bus_reset && !evt_i.setup_token |=> stl_r == ($past(reg_wdata_i) & 8'h77))
    else $error("stall write not stored");

  chk_pullup_bit : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE2
    wr_ctl |=> {dminus_pullup_o, 7'h00} == ($past(reg_wdata_i) & 8'h80))
    else $error("pull-up does not follow bit 7");

  chk_osc_bit : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE3
    wr_ctl |=> {1'b0, osc_freq_select_o, 6'h00} == ($past(reg_wdata_i) & 8'h40))
    else $error("oscillator select does not follow bit 6");

  chk_ep_upper : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE4
    ctl_r[`CTL_EPSEL_HI_BIT] |-> fifo_ep_o == usb_sie_ctrl_pkg::EP_TWO)
    else $error("upper select codes not endpoint 2");

  chk_wake_bit : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE6
    wr_adr |=> {7'h00, remote_wake_allow_o} == ($past(reg_wdata_i) & 8'h01))
    else $error("wake enable does not follow bit 0");

  chk_addr_store : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE5
    wr_adr |=> adr_r == $past(reg_wdata_i))
    else $error("address write not stored");

  chk_addr_apply : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE19
    clk_en_i && apply_r && evt_i.in_read_ok |=> {active_addr_o, 1'b0} == ($past(adr_r) & 8'hFE))
    else $error("stored address not adopted after IN read");

  chk_in_seen : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE16
    clk_en_i && evt_i.in_token |=> sts_view[`STS_IN_BIT])
    else $error("IN token not shown");

  chk_in_gone : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE16
    clk_en_i && !evt_i.in_token |=> !sts_view[`STS_IN_BIT])
    else $error("IN token shown without token");

  chk_frozen_state : assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE2 RULE9
    !clk_en_i |=> $stable(ctl_r) && $stable(adr_r) && $stable(stl_r) && $stable(usb_irq_o))
    else $error("state moved while frozen");

endmodule

// ### test/usb_host_model.sv
`timescale 1ns/100ps
// stands in for the bus side; pulses last one clock edge, enabled or not, levels hold
module usb_host_model (
  input  wire logic                          core_clk_i,
  output usb_sie_ctrl_pkg::engine_event_type evt_o
);
  initial evt_o = '0;

  task automatic pulse(input logic [9:0] e);
    @(posedge core_clk_i);
    evt_o <= usb_sie_ctrl_pkg::engine_event_type'(evt_o | e);
    @(posedge core_clk_i);
    evt_o <= usb_sie_ctrl_pkg::engine_event_type'(evt_o & ~e);
    #1;
  endtask

  task automatic level(input logic sus, input logic tok);
    @(posedge core_clk_i);
    evt_o.suspend  <= sus;
    evt_o.in_token <= tok;
    #1;
  endtask
endmodule

// ### test/tb_usb_sie_control_status.sv
`timescale 1ns/100ps
module tb_usb_sie_control_status;
  localparam logic [9:0] ev_rst   = 10'h200;
  localparam logic [9:0] ev_setup = 10'h100;
  localparam logic [9:0] ev_out   = 10'h020;
  localparam logic [9:0] ev_nak   = 10'h010;
  localparam logic [9:0] ev_rx    = 10'h008;
  localparam logic [9:0] ev_inok  = 10'h001;
  logic                               core_clk_i  = 1'b0;
  logic                               rst_i       = 1'b1;
  logic                               clk_en_i    = 1'b1;
  logic [1:0]                         reg_addr_i  = 2'h0;
  logic [7:0]                         reg_wdata_i = 8'h00;
  logic                               reg_wr_i    = 1'b0;
  logic                               reg_rd_i    = 1'b0;
  logic [7:0]                         reg_rdata_o;
  usb_sie_ctrl_pkg::engine_event_type evt_i;
  logic                               usb_irq_o;
  logic                               pu_o;
  logic                               osc_o;
  logic                               clkon_o;
  logic                               slp2_o;
  usb_sie_ctrl_pkg::ep_sel_type       fifo_ep_o;
  logic [6:0]                         active_addr_o;
  logic                               wake_o;
  logic [2:0]                         out_halt_o;
  logic [2:0]                         in_halt_o;
  int                                 err_count = 0;
  int                                 n_tests   = 0;

  always #5 core_clk_i = ~core_clk_i;

  usb_sie_control_status u_usb_sie_control_status (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .evt_i(evt_i), .usb_irq_o(usb_irq_o),
    .dminus_pullup_o(pu_o), .osc_freq_select_o(osc_o), .engine_clock_on_o(clkon_o),
    .second_sleep_control_o(slp2_o), .fifo_ep_o(fifo_ep_o), .active_addr_o(active_addr_o),
    .remote_wake_allow_o(wake_o), .out_halt_o(out_halt_o), .in_halt_o(in_halt_o));

  usb_host_model u_usb_host_model (.core_clk_i(core_clk_i), .evt_o(evt_i));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rdata", exp, reg_rdata_o);
  endtask

  task automatic t_control;
    wr(2'h0, 8'hFF);
    chk("pullup", 8'h01, 8'(pu_o));
    chk("osc", 8'h01, 8'(osc_o));
    chk("clkon", 8'h01, 8'(clkon_o));
    chk("sleep2", 8'h01, 8'(slp2_o));
    rd(2'h0, 8'hDB);
    wr(2'h0, 8'h00);
    chk("pullup", 8'h00, 8'(pu_o));
    chk("osc", 8'h00, 8'(osc_o));
    chk("clkon", 8'h00, 8'(clkon_o));
    chk("sleep2", 8'h00, 8'(slp2_o));
    chk("epsel", 8'(usb_sie_ctrl_pkg::EP_CTRL0), 8'(fifo_ep_o));
    wr(2'h0, 8'h01);
    chk("epsel", 8'(usb_sie_ctrl_pkg::EP_ONE), 8'(fifo_ep_o));
    wr(2'h0, 8'h02);
    chk("epsel", 8'(usb_sie_ctrl_pkg::EP_TWO), 8'(fifo_ep_o));
    wr(2'h0, 8'h03);
    chk("epsel", 8'(usb_sie_ctrl_pkg::EP_TWO), 8'(fifo_ep_o));
  endtask

  task automatic t_address;
    u_usb_host_model.pulse(ev_setup);
    wr(2'h1, 8'h0B);
    chk("addr", 8'h05, 8'(active_addr_o));
    chk("wake", 8'h01, 8'(wake_o));
    wr(2'h3, 8'h01);
    wr(2'h1, 8'h14);
    chk("addr", 8'h05, 8'(active_addr_o));
    chk("wake", 8'h00, 8'(wake_o));
    u_usb_host_model.pulse(ev_inok);
    chk("addr", 8'h0A, 8'(active_addr_o));
    u_usb_host_model.pulse(ev_setup);
    wr(2'h3, 8'h00);
  endtask

  task automatic t_stall;
    wr(2'h2, 8'hFF);
    chk("outhalt", 8'h07, 8'(out_halt_o));
    chk("inhalt", 8'h07, 8'(in_halt_o));
    rd(2'h2, 8'h77);
    u_usb_host_model.pulse(ev_setup);
    rd(2'h2, 8'h00);
    wr(2'h2, 8'h41);
    chk("outhalt", 8'h04, 8'(out_halt_o));
    chk("inhalt", 8'h01, 8'(in_halt_o));
    u_usb_host_model.pulse(ev_rst);
    rd(2'h2, 8'h00);
  endtask

  task automatic t_flags;
    u_usb_host_model.pulse(10'h02E);
    rd(2'h3, 8'h56);
    wr(2'h3, 8'h00);
    rd(2'h3, 8'h00);
    u_usb_host_model.pulse(ev_out);
    rd(2'h3, 8'h04);
    u_usb_host_model.pulse(ev_setup);
    rd(2'h3, 8'h00);
    fork
      u_usb_host_model.pulse(ev_rx);
      wr(2'h3, 8'h00);
    join
    rd(2'h3, 8'h40);
    wr(2'h3, 8'h00);
    u_usb_host_model.level(1'b0, 1'b1);
    rd(2'h3, 8'h08);
    u_usb_host_model.level(1'b0, 1'b0);
    rd(2'h3, 8'h00);
  endtask

  task automatic t_irq;
    u_usb_host_model.pulse(ev_nak);
    chk("irq", 8'h01, 8'(usb_irq_o));
    wr(2'h3, 8'h80);
    u_usb_host_model.pulse(ev_nak);
    chk("irq", 8'h00, 8'(usb_irq_o));
    wr(2'h0, 8'h08);
    chk("clkon", 8'h01, 8'(clkon_o));
    chk("sleep2", 8'h00, 8'(slp2_o));
    u_usb_host_model.level(1'b1, 1'b0);
    @(posedge core_clk_i);
    #1;
    chk("irq", 8'h00, 8'(usb_irq_o));
    @(posedge core_clk_i);
    #1;
    chk("irq", 8'h01, 8'(usb_irq_o));
    @(posedge core_clk_i);
    #1;
    chk("irq", 8'h00, 8'(usb_irq_o));
  endtask

  // enable low must swallow both a register write and an event
  task automatic t_freeze;
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    wr(2'h0, 8'h80);
    u_usb_host_model.pulse(ev_rx);
    chk("pullup", 8'h00, 8'(pu_o));
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    rd(2'h3, 8'h80);
  endtask

  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(2'h1, 8'h00);
    chk("addr", 8'h00, 8'(active_addr_o));
    t_control();
    t_address();
    t_stall();
    t_flags();
    t_irq();
    t_freeze();
    give_verdict();
  end

  // whole run is about a hundred cycles
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
endmodule
